/* File: rtl/pdwi_defines.vh */
`ifndef PDWI_DEFINES_VH
`define PDWI_DEFINES_VH

// Wake dependency register layout
`define PDWI_WKDEP_W 8
`define PDWI_WKDEP_EN_BIT 4
`define PDWI_WKDEP_RST 8'h00

// Seed of the supply loss scrambler
`define PDWI_SCRAM_SEED 1'b1

// Timing: peripheral reset hold and pad restore time in ns
`define PDWI_PER_RST_NS 200
`define PDWI_RESTORE_NS 100
`define PDWI_CLK_NS 20

// Power states
`define PDWI_PST_ON 2'h0
`define PDWI_PST_RET 2'h1
`define PDWI_PST_OFF 2'h2

`endif

/* File: rtl/pdwi_sequencer.v */
// Contract
// - Dependency-woken domain stays out of low power until software marks it used
// - Sleep-dependency partner active before going inactive
// - Initiator must leave standby before low power
// - Pad configuration restored by hardware on wake
// - Latches drive GPIO until peripheral wakes
// - Latches have no reset value
// - Always-on domain pins unaffected by latch randomness
// - Bit 4 links always-on wake to peripheral
// - Inner latches release before pad isolation
// - GPIO pins come out of reset as inputs
`timescale 1ns/1ps
`include "pdwi_defines.vh"

module pdwi_sequencer #(
    parameter NGPIO = 8
) (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Software control
    input wire [`PDWI_WKDEP_W-1:0] peripheral_wake_dependency_register,
    input wire sw_per_wake_req,
    input wire sw_lowpower_req,
    input wire [1:0] sw_lowpower_target,
    input wire sw_domain_used,
    input wire sleep_dep_en,
    input wire is_initiator,
    input wire [NGPIO-1:0] sw_gpio_oe,
    input wire [NGPIO-1:0] sw_gpio_out,
    input wire sw_gpio_restored,
    // Asynchronous wake and status inputs
    input wire always_on_wake_domain,
    input wire sleep_partner_active,
    input wire initiator_standby,
    input wire core_logic_supply_ok,
    // Power state status
    output reg [1:0] per_power_state,
    output reg per_dep_woken,
    output reg per_lowpower_blocked,
    output reg padconf_restore_busy,
    output reg per_reset_n,
    // Isolation and pads
    output reg inner_latch_release,
    output reg pad_iso_release,
    output reg [NGPIO-1:0] gpio_oe,
    output reg [NGPIO-1:0] gpio_out
);

    //--------------------------------------------------------------
    // Timing
    //--------------------------------------------------------------
    localparam RST_CYC = (`PDWI_PER_RST_NS + `PDWI_CLK_NS - 1) / `PDWI_CLK_NS;
    localparam RES_CYC = (`PDWI_RESTORE_NS + `PDWI_CLK_NS - 1) / `PDWI_CLK_NS;
    localparam CW = 8;

    //--------------------------------------------------------------
    // States
    //--------------------------------------------------------------
    localparam S_ON = 7'h01;
    localparam S_LOW = 7'h02;
    localparam S_RESTORE = 7'h04;
    localparam S_PWRUP = 7'h08;
    localparam S_INNER = 7'h10;
    localparam S_PAD = 7'h20;
    localparam S_WAIT = 7'h40;

    //--------------------------------------------------------------
    // Input synchronisers
    //--------------------------------------------------------------
    reg [3:0] sync1_q;
    reg [3:0] sync2_q;
    reg wake_prev_q;
    wire aon_wake = sync2_q[0];
    wire partner_act = sync2_q[1];
    wire standby = sync2_q[2];
    wire supply_ok = sync2_q[3];

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            wake_prev_q <= 1'b0;
        end
        else
        begin
            sync1_q <= {core_logic_supply_ok, initiator_standby, sleep_partner_active, always_on_wake_domain};
            sync2_q <= sync1_q;
            wake_prev_q <= sync2_q[0];
        end
    end

    //--------------------------------------------------------------
    // Wake detect and gating
    //--------------------------------------------------------------
    wire aon_wake_rise = aon_wake & ~wake_prev_q;
    wire dep_en = peripheral_wake_dependency_register[`PDWI_WKDEP_EN_BIT];
    wire dep_wake = aon_wake_rise & dep_en;

    wire cond_sleep = ~sleep_dep_en | partner_act;
    wire cond_init = ~is_initiator | ~standby;
    wire lp_allowed = ~per_dep_woken | (sw_domain_used & cond_sleep & cond_init);

    //--------------------------------------------------------------
    // Sequencer
    //--------------------------------------------------------------
    reg [6:0] state_q;
    reg [CW-1:0] cnt_q;
    reg [NGPIO-1:0] latch_oe_q;
    reg [NGPIO-1:0] latch_val_q;

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= S_ON;
            cnt_q <= {CW{1'b0}};
            per_power_state <= `PDWI_PST_ON;
            per_dep_woken <= 1'b0;
            per_lowpower_blocked <= 1'b0;
            padconf_restore_busy <= 1'b0;
            per_reset_n <= 1'b1;
            inner_latch_release <= 1'b1;
            pad_iso_release <= 1'b1;
        end
        else
        begin
            per_lowpower_blocked <= sw_lowpower_req & ~lp_allowed;
            case (state_q)
                S_ON:
                begin
                    if (sw_lowpower_req && lp_allowed && sw_lowpower_target != `PDWI_PST_ON)
                    begin
                        state_q <= S_LOW;
                        per_power_state <= sw_lowpower_target;
                        per_dep_woken <= 1'b0;
                        inner_latch_release <= 1'b0;
                        pad_iso_release <= 1'b0;
                    end
                end
                S_LOW:
                begin
                    if ((dep_wake || sw_per_wake_req) && supply_ok)
                    begin
                        per_dep_woken <= dep_wake & ~sw_per_wake_req;
                        state_q <= S_RESTORE;
                        padconf_restore_busy <= 1'b1;
                        cnt_q <= RES_CYC[CW-1:0];
                    end
                end
                S_RESTORE:
                begin
                    if (cnt_q == {CW{1'b0}})
                    begin
                        padconf_restore_busy <= 1'b0;
                        per_power_state <= `PDWI_PST_ON;
                        per_reset_n <= 1'b0;
                        cnt_q <= RST_CYC[CW-1:0];
                        state_q <= S_PWRUP;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
                    end
                end
                S_PWRUP:
                begin
                    if (cnt_q == {CW{1'b0}})
                    begin
                        per_reset_n <= 1'b1;
                        state_q <= S_INNER;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
                    end
                end
                S_INNER:
                begin
                    inner_latch_release <= 1'b1;
                    state_q <= S_PAD;
                end
                S_PAD:
                begin
                    pad_iso_release <= 1'b1;
                    state_q <= S_WAIT;
                end
                S_WAIT:
                begin
                    state_q <= S_ON;
                end
                default:
                begin
                    state_q <= S_ON;
                end
            endcase
        end
    end

    //--------------------------------------------------------------
    // GPIO module
    //--------------------------------------------------------------
    // GPIO module reset to inputs
    reg gpio_restored_q;
    wire [NGPIO-1:0] gpio_core_oe = gpio_restored_q ? sw_gpio_oe : {NGPIO{1'b0}};
    wire [NGPIO-1:0] gpio_core_out = sw_gpio_out;

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gpio_restored_q <= 1'b0;
        end
        else if (!per_reset_n)
        begin
            gpio_restored_q <= 1'b0;
        end
        else if (sw_gpio_restored)
        begin
            gpio_restored_q <= 1'b1;
        end
    end

    //--------------------------------------------------------------
    // Supply loss scrambler
    //--------------------------------------------------------------
    // Random level while unpowered
    // Stands in for the lost latch content
    // Needs NGPIO of two or more
    reg [NGPIO-1:0] scram_q;

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scram_q <= {{(NGPIO-1){1'b0}}, `PDWI_SCRAM_SEED};
        end
        else
        begin
            scram_q <= {scram_q[NGPIO-2:0], scram_q[NGPIO-1] ^ scram_q[0]};
        end
    end

    //--------------------------------------------------------------
    // Isolation latches
    //--------------------------------------------------------------
    // No reset: content lost with the supply
    always @(posedge mclk)
    begin
        if (!supply_ok)
        begin
            latch_oe_q <= scram_q;
            latch_val_q <= ~scram_q;
        end
        else if (inner_latch_release)
        begin
            latch_oe_q <= gpio_core_oe;
            latch_val_q <= gpio_core_out;
        end
    end

    //--------------------------------------------------------------
    // Pad drive
    //--------------------------------------------------------------
    // Latches drive pads while isolated
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gpio_oe <= {NGPIO{1'b0}};
            gpio_out <= {NGPIO{1'b0}};
        end
        else if (!pad_iso_release)
        begin
            gpio_oe <= latch_oe_q;
            gpio_out <= latch_val_q;
        end
        else
        begin
            gpio_oe <= gpio_core_oe;
            gpio_out <= gpio_core_out;
        end
    end

    // Always-on pins are outside this path

endmodule // pdwi_sequencer

/* File: test/pdwi_checker.sv */
`timescale 1ns/1ps
module pdwi_checker (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Software control
    input wire sw_lowpower_req,
    input wire [1:0] sw_lowpower_target,
    input wire sw_domain_used,
    input wire sleep_dep_en,
    input wire is_initiator,
    input wire sleep_partner_active,
    input wire initiator_standby,
    // Sequencer outputs
    input wire [1:0] per_power_state,
    input wire per_dep_woken,
    input wire padconf_restore_busy,
    input wire per_reset_n,
    input wire inner_latch_release,
    input wire pad_iso_release
);
    // ----
    // Assertions
    // ----
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_BLK: assert property (
        per_dep_woken && !sw_domain_used && per_power_state == 2'h0 |=> per_power_state == 2'h0)
        else $error("unused woken domain left on state");
    AST_SLP: assert property (
        (per_dep_woken && sleep_dep_en && !sleep_partner_active && per_power_state == 2'h0) [*4]
        |=> per_power_state == 2'h0) else $error("left on state without sleep partner");
    AST_STB: assert property (
        (per_dep_woken && is_initiator && initiator_standby && per_power_state == 2'h0) [*4]
        |=> per_power_state == 2'h0) else $error("left on state while in standby");
    AST_LP: assert property (
        $past(pad_iso_release, 3) && pad_iso_release && per_power_state == 2'h0 && sw_lowpower_req
        && !per_dep_woken && sw_lowpower_target != 2'h0 |=> per_power_state == $past(sw_lowpower_target)
        && !pad_iso_release && !inner_latch_release) else $error("free request not taken");
    AST_BUSY: assert property (
        $rose(padconf_restore_busy) |-> padconf_restore_busy [*6] ##1 (!padconf_restore_busy && !per_reset_n))
        else $error("pad restore length wrong");
    AST_RSTLEN: assert property (
        $fell(per_reset_n) |-> ##11 (per_reset_n && !inner_latch_release)
        ##1 (inner_latch_release && !pad_iso_release) ##1 pad_iso_release) else $error("release order wrong");
    AST_ORD: assert property (
        $rose(pad_iso_release) |-> $past(inner_latch_release) && inner_latch_release)
        else $error("pad isolation released first");
    AST_ISO: assert property (
        !per_reset_n |-> !pad_iso_release && !inner_latch_release && per_power_state == 2'h0)
        else $error("isolation released during reset");
endmodule // pdwi_checker

bind pdwi_sequencer pdwi_checker chk_u (.*);

/* File: test/pdwi_pads.sv */
`timescale 1ns/1ps
module pdwi_pads #(
    parameter [7:0] PULL = 8'hA5
) (
    // Pad drive
    input wire [7:0] gpio_oe,
    input wire [7:0] gpio_out,
    // Line level
    output wire [7:0] pad_line
);
    assign pad_line = (gpio_oe & gpio_out) | (~gpio_oe & PULL);
endmodule // pdwi_pads

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; $display("[ERR] %0t check %0d", $time, num_checks); end end
module tb_top;
    // ----
    // Signals
    // ----
    reg mclk = 0, rst_n = 0, sw_per_wake_req = 0, sw_lowpower_req = 0, sw_domain_used = 0;
    reg sleep_dep_en = 0, is_initiator = 0, sw_gpio_restored = 0, always_on_wake_domain = 0;
    reg sleep_partner_active = 0, initiator_standby = 0, core_logic_supply_ok = 1;
    reg [7:0] peripheral_wake_dependency_register = 8'h00, sw_gpio_oe = 8'h00, sw_gpio_out = 8'h00;
    reg [1:0] sw_lowpower_target = 2'h0;
    wire [1:0] per_power_state;
    wire per_dep_woken, per_lowpower_blocked, padconf_restore_busy, per_reset_n;
    wire inner_latch_release, pad_iso_release;
    wire [7:0] gpio_oe, gpio_out, pad_line;
    int n_errors = 0, num_checks = 0, n;
    always #10 mclk = ~mclk;
    pdwi_sequencer #(.NGPIO(8)) dut_u (.*);
    pdwi_pads pads_u (.*);
    // ----
    // Reference model
    // ----
    int m_state = 0, m_woken = 0;
    int exp_q[$];
    function automatic int m_allowed();
        return (m_woken == 0) || (sw_domain_used && (!sleep_dep_en || sleep_partner_active)
            && (!is_initiator || !initiator_standby));
    endfunction
    // ----
    // Tasks
    // ----
    task tick;
        @(posedge mclk);
        #1;
    endtask
    task results;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task lp(input [1:0] t, input blk);
        int eb;
        eb = (m_allowed() == 0);
        if (eb == 0 && t != 2'h0)
        begin
            m_state = t;
            m_woken = 0;
        end
        exp_q.push_back(m_state);
        sw_lowpower_target = t;
        sw_lowpower_req = 1;
        tick;
        tick;
        `CHK(per_lowpower_blocked, blk)
        `CHK(per_lowpower_blocked, eb[0])
        `CHK(per_power_state, blk ? 2'h0 : t)
        `CHK(per_power_state, exp_q.pop_front())
        sw_lowpower_req = 0;
        tick;
        $display("test low power %0d done", t);
    endtask
    task wake(input bit aw);
        int i;
        m_woken = aw && peripheral_wake_dependency_register[4];
        m_state = 0;
        if (aw)
            always_on_wake_domain = 1;
        else
            sw_per_wake_req = 1;
        for (i = 0; i < 20 && padconf_restore_busy !== 1'b1; i++)
            tick;
        always_on_wake_domain = 0;
        sw_per_wake_req = 0;
        if (i == 20)
        begin
            n_errors++;
            results;
        end
        `CHK(per_dep_woken, aw)
        `CHK(per_dep_woken, m_woken[0])
        n = 0;
        while (padconf_restore_busy === 1'b1 && n < 30)
        begin
            n++;
            tick;
        end
        `CHK(n, 6)
        if (n == 30)
            results;
        n = 0;
        while (per_reset_n === 1'b0 && n < 30)
        begin
            n++;
            tick;
        end
        `CHK(n, 11)
        if (n == 30)
            results;
        `CHK(inner_latch_release, 1'b0)
        tick;
        `CHK({inner_latch_release, pad_iso_release}, 2'b10)
        tick;
        `CHK(pad_iso_release, 1'b1)
        `CHK(per_power_state, m_state)
        repeat (4) tick;
        $display("test wake %0d done", aw);
    endtask
    // ----
    // Sequence
    // ----
    initial
    begin
        void'($urandom(32'had5a48fe));
        repeat (6) tick;
        rst_n = 1;
        `CHK({per_power_state, pad_iso_release, gpio_oe}, {2'h0, 1'b1, 8'h00})
        lp(2'h2, 0);
        always_on_wake_domain = 1;
        repeat (6) tick;
        always_on_wake_domain = 0;
        `CHK(padconf_restore_busy, 1'b0)
        `CHK(per_power_state, m_state)
        core_logic_supply_ok = 0;
        repeat (3) tick;
        sw_per_wake_req = 1;
        repeat (6) tick;
        sw_per_wake_req = 0;
        `CHK(per_power_state, 2'h2)
        `CHK(per_power_state, m_state)
        core_logic_supply_ok = 1;
        peripheral_wake_dependency_register = 8'h10;
        repeat (3) tick;
        wake(1);
        sleep_dep_en = 1;
        is_initiator = 1;
        initiator_standby = 1;
        lp(2'h1, 1);
        sw_domain_used = 1;
        lp(2'h1, 1);
        sleep_partner_active = 1;
        repeat (4) tick;
        lp(2'h1, 1);
        initiator_standby = 0;
        repeat (4) tick;
        lp(2'h1, 0);
        wake(0);
        `CHK(gpio_oe, 8'h00)
        sw_gpio_oe = 8'($urandom);
        sw_gpio_out = 8'($urandom);
        sw_gpio_restored = 1;
        tick;
        tick;
        sw_gpio_restored = 0;
        `CHK({gpio_oe, gpio_out}, {sw_gpio_oe, sw_gpio_out})
        `CHK(pad_line, (sw_gpio_oe & sw_gpio_out) | (~sw_gpio_oe & 8'hA5))
        $display("test restore done");
        results;
    end
endmodule // tb_top
